// file: inc/vetc_pkg.sv
// Package of constants for the video encoder timing control block
package vetc_pkg;
  // Reference clock rate assumed for cycle counts (200 MHz, 5 ns)
  localparam int CLK_PERIOD_PS = 5000;
  // Printed times in nanoseconds
  localparam int NTSC_SYNC_MIN_NS = 2800;
  localparam int NTSC_SYNC_MAX_NS = 5300;
  localparam int PAL_SYNC_MIN_NS  = 3300;
  localparam int PAL_SYNC_MAX_NS  = 5400;
  localparam int OFFS_START_NS    = 8400;
  localparam int OFFS_WIDTH_NS    = 1000;
  localparam int BURST_START_NS   = 5700;
  localparam int NTSC_BURST_W_NS  = 2500;
  localparam int PAL_BURST_W_NS   = 2300;
  localparam int CHECK_WIDTH_NS   = 18000;
  // Derived cycle counts: minima round up, maxima round down
  localparam int CW = 13;
  localparam logic [CW-1:0] NTSC_SYNC_MIN = CW'((NTSC_SYNC_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [CW-1:0] NTSC_SYNC_MAX = CW'((NTSC_SYNC_MAX_NS * 1000) / CLK_PERIOD_PS);
  localparam logic [CW-1:0] PAL_SYNC_MIN  = CW'((PAL_SYNC_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [CW-1:0] PAL_SYNC_MAX  = CW'((PAL_SYNC_MAX_NS * 1000) / CLK_PERIOD_PS);
  localparam logic [CW-1:0] OFFS_START    = CW'((OFFS_START_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [CW-1:0] OFFS_END      = CW'(((OFFS_START_NS + OFFS_WIDTH_NS) * 1000) / CLK_PERIOD_PS);
  localparam logic [CW-1:0] BURST_START   = CW'((BURST_START_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [CW-1:0] NTSC_BURST_END = CW'(((BURST_START_NS + NTSC_BURST_W_NS) * 1000) / CLK_PERIOD_PS);
  localparam logic [CW-1:0] PAL_BURST_END  = CW'(((BURST_START_NS + PAL_BURST_W_NS) * 1000) / CLK_PERIOD_PS);
  localparam logic [CW-1:0] CHECK_END      = CW'((CHECK_WIDTH_NS * 1000) / CLK_PERIOD_PS);
  localparam logic [CW-1:0] CNT_SAT        = {CW{1'b1}};
  // Field counter
  localparam int FW = 6;
  localparam logic [FW-1:0] FIELD_LAST = 6'h3F;
  // Burst vector sign encodings (sign bit, enable bit)
  localparam logic [1:0] AX_ZERO = 2'h0;
  localparam logic [1:0] AX_POS  = 2'h1;
  localparam logic [1:0] AX_NEG  = 2'h3;
  // Load check state machine
  typedef enum logic [1:0] {LC_IDLE, LC_WAIT, LC_SAMPLE} vetc_lc_e;
endpackage : vetc_pkg

// file: design/vetc_sync2.sv
// Two-flop synchroniser, parameterised width
`timescale 1ns/1ps
module vetc_sync2 #(
  parameter int W = 1
) (
  input  wire logic         core_clk_i,
  input  wire logic         reset_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] stage1;
  logic [W-1:0] next_stage1;
  logic [W-1:0] next_sync;

  // Next values: shift through two stages
  always_comb
  begin
    next_stage1 = async_i;
    next_sync   = stage1;
  end

  // Register both stages
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      stage1 <= '1;
      sync_o <= '1;
    end
    else
    begin
      stage1 <= next_stage1;
      sync_o <= next_sync;
    end
  end
endmodule // vetc_sync2

// file: design/vetc_timing.sv
// Timing control: subcarrier phases, burst, offset window, load checks
`timescale 1ns/1ps
module vetc_timing (
  input  wire logic       core_clk_i,
  input  wire logic       reset_i,
  input  wire logic       hsync_n_i,          // Pin: horizontal or composite sync
  input  wire logic       vsync_n_i,          // Pin: vertical sync, high for composite
  input  wire logic       pal_mode_i,         // Pin: 1 selects PAL
  input  wire logic       enable_i,           // Pin: enable, gates only the start of a load check
  input  wire logic       luma_load_ok_i,     // Comparator: load seen on luma
  input  wire logic       composite_load_ok_i,// Comparator: load seen on composite_out
  output logic            combined_sync_n_o,
  output logic            sub_sin_o,
  output logic            sub_cos_o,
  output logic            burst_gate_o,
  output logic [1:0]      burst_u_o,
  output logic [1:0]      burst_v_o,
  output logic            offset_cancel_o,
  output logic            load_check_o,
  output logic            luma_drive_on_o,
  output logic            chroma_drive_pin_o,
  output logic            composite_drive_on_o,
  output logic            luma_tv_presence_flag_o,
  output logic            composite_tv_presence_flag_o,
  output logic            tv_presence_flag_o
);
  import vetc_pkg::*;

  logic [5:0] pins_s;
  logic       y_load_s;
  logic       cv_load_s;
  logic       hs_s;
  logic       vs_s;
  logic       pal_s;
  logic       en_s;
  logic       sync_n;
  logic       sync_prev;
  logic       fall;
  logic       rise;
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic [1:0] phase;
  logic [1:0] next_phase;
  logic       v_inv;
  logic       next_v_inv;
  logic       in_pulse;
  logic       next_in_pulse;
  logic       width_ok;
  logic       next_width_ok;
  logic       line_ok;
  logic       next_line_ok;
  logic       vert_seen;
  logic       next_vert_seen;
  logic       combined_sync_q;
  logic       next_combined_sync;
  logic       sin_q;
  logic       cos_q;
  logic       next_sin;
  logic       next_cos;
  logic       gate_q;
  logic       next_gate;
  logic [1:0] bu_q;
  logic [1:0] bv_q;
  logic [1:0] next_bu;
  logic [1:0] next_bv;
  logic       offs_q;
  logic       next_offs;
  logic [CW-1:0] smin;
  logic [CW-1:0] smax;
  logic [CW-1:0] bend;
  logic [FW-1:0] field;
  logic [FW-1:0] next_field;
  vetc_lc_e   lc;
  vetc_lc_e   next_lc;
  logic [CW-1:0] lc_cnt;
  logic [CW-1:0] next_lc_cnt;
  logic       y_on;
  logic       cv_on;
  logic       next_y_on;
  logic       next_cv_on;
  logic       chk_q;
  logic       next_chk;
  logic       tv_q;
  logic       next_tv;

  // Pin and comparator inputs through two flops
  vetc_sync2 #(.W(6)) u_sync (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .async_i    ({luma_load_ok_i, composite_load_ok_i, hsync_n_i, vsync_n_i, pal_mode_i, enable_i}),
    .sync_o     (pins_s)
  );
  assign hs_s  = pins_s[3];
  assign vs_s  = pins_s[2];
  assign pal_s = pins_s[1];
  assign en_s  = pins_s[0];
  assign y_load_s  = pins_s[5];
  assign cv_load_s = pins_s[4];

  // Combine syncs, find edges
  assign sync_n = ~(hs_s ^ vs_s);
  assign fall   = sync_prev & ~sync_n;
  assign rise   = ~sync_prev & sync_n;
  // Mode constants selected by standard input
  assign smin = pal_s ? PAL_SYNC_MIN : NTSC_SYNC_MIN;
  assign smax = pal_s ? PAL_SYNC_MAX : NTSC_SYNC_MAX;
  assign bend = pal_s ? PAL_BURST_END : NTSC_BURST_END;

  // Line timing next values
  always_comb
  begin
    next_phase     = phase + 2'h1;
    next_cnt       = (cnt == CNT_SAT) ? cnt : cnt + 1'b1;
    next_v_inv     = v_inv;
    next_in_pulse  = in_pulse;
    next_width_ok  = width_ok;
    next_line_ok   = line_ok;
    next_vert_seen = 1'b0;
    if (fall)
    begin
      next_cnt      = '0;
      next_in_pulse = 1'b1;
      next_line_ok  = 1'b0;
      if (pal_s)
        next_v_inv = ~v_inv;
    end
    else if (rise && in_pulse)
    begin
      next_in_pulse  = 1'b0;
      // Pulse lasted cnt + 1 cycles when its rise is seen
      next_width_ok  = (cnt >= smin - 1'b1) && (cnt < smax);
      next_line_ok   = next_width_ok;
      next_vert_seen = ~next_width_ok;
    end
    // Outputs of line timing
    next_combined_sync = sync_n;
    next_sin   = phase[1];
    next_cos   = phase[1] ^ phase[0] ^ v_inv;
    next_gate  = line_ok && !in_pulse && (cnt >= BURST_START) && (cnt < bend);
    next_bu    = next_gate ? AX_NEG : AX_ZERO;
    if (next_gate && pal_s)
      next_bv = v_inv ? AX_NEG : AX_POS;
    else
      next_bv = AX_ZERO;
    next_offs  = (cnt >= OFFS_START) && (cnt < OFFS_END);
  end

  // Line timing registers
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      sync_prev <= 1'b1;
      cnt       <= CNT_SAT;
      phase     <= 2'h0;
      v_inv     <= 1'b0;
      in_pulse  <= 1'b0;
      width_ok  <= 1'b0;
      line_ok   <= 1'b0;
      vert_seen <= 1'b0;
      combined_sync_q   <= 1'b1;
      sin_q     <= 1'b0;
      cos_q     <= 1'b0;
      gate_q    <= 1'b0;
      bu_q      <= AX_ZERO;
      bv_q      <= AX_ZERO;
      offs_q    <= 1'b0;
    end
    else
    begin
      sync_prev <= sync_n;
      cnt       <= next_cnt;
      phase     <= next_phase;
      v_inv     <= next_v_inv;
      in_pulse  <= next_in_pulse;
      width_ok  <= next_width_ok;
      line_ok   <= next_line_ok;
      vert_seen <= next_vert_seen;
      combined_sync_q   <= next_combined_sync;
      sin_q     <= next_sin;
      cos_q     <= next_cos;
      gate_q    <= next_gate;
      bu_q      <= next_bu;
      bv_q      <= next_bv;
      offs_q    <= next_offs;
    end
  end

  // Load check next values; first vertical interval of a field starts count
  always_comb
  begin
    next_field  = field;
    next_lc     = lc;
    next_lc_cnt = lc_cnt;
    next_y_on   = y_on;
    next_cv_on  = cv_on;
    next_chk    = 1'b0;
    case (lc)
      LC_IDLE:
      begin
        if (vert_seen)
        begin
          next_lc = LC_WAIT;
          next_field = field + 1'b1;
          if (field == FIELD_LAST && en_s)
          begin
            next_lc     = LC_SAMPLE;
            next_lc_cnt = '0;
          end
        end
      end
      LC_WAIT:
      begin
        // Remaining half-line pulses of the same field are ignored
        if (line_ok)
          next_lc = LC_IDLE;  // Full-width line seen
      end
      LC_SAMPLE:
      begin
        next_chk    = 1'b1;
        next_lc_cnt = lc_cnt + 1'b1;
        if (lc_cnt == CHECK_END)
        begin
          next_lc    = LC_WAIT;
          next_chk   = 1'b0;
          next_y_on  = y_load_s;
          next_cv_on = cv_load_s;
        end
      end
      default:
        next_lc = LC_IDLE;
    endcase
    next_tv = next_y_on | next_cv_on;
  end

  // Load check registers
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      field  <= '0;
      lc     <= LC_IDLE;
      lc_cnt <= '0;
      y_on   <= 1'b0;
      cv_on  <= 1'b0;
      chk_q  <= 1'b0;
      tv_q   <= 1'b0;
    end
    else
    begin
      field  <= next_field;
      lc     <= next_lc;
      lc_cnt <= next_lc_cnt;
      y_on   <= next_y_on;
      cv_on  <= next_cv_on;
      chk_q  <= next_chk;
      tv_q   <= next_tv;
    end
  end

  // Outputs straight from flops
  assign combined_sync_n_o            = combined_sync_q;
  assign sub_sin_o                    = sin_q;
  assign sub_cos_o                    = cos_q;
  assign burst_gate_o                 = gate_q;
  assign burst_u_o                    = bu_q;
  assign burst_v_o                    = bv_q;
  assign offset_cancel_o              = offs_q;
  assign load_check_o                 = chk_q;
  assign luma_drive_on_o              = y_on;
  assign chroma_drive_pin_o           = y_on;
  assign composite_drive_on_o         = cv_on;
  assign luma_tv_presence_flag_o      = y_on;
  assign composite_tv_presence_flag_o = cv_on;
  assign tv_presence_flag_o           = tv_q;
endmodule // vetc_timing

// file: sim/vetc_timing_properties.sv
// Port-level checker for the timing control block
`timescale 1ns/1ps
module vetc_timing_chk
  import vetc_pkg::*;
(
  input wire logic       core_clk_i,
  input wire logic       reset_i,
  input wire logic       hsync_n_i,
  input wire logic       vsync_n_i,
  input wire logic       pal_mode_i,
  input wire logic       combined_sync_n_o,
  input wire logic       sub_sin_o,
  input wire logic       burst_gate_o,
  input wire logic [1:0] burst_u_o,
  input wire logic [1:0] burst_v_o,
  input wire logic       offset_cancel_o,
  input wire logic       load_check_o,
  input wire logic       luma_drive_on_o,
  input wire logic       chroma_drive_pin_o,
  input wire logic       composite_drive_on_o,
  input wire logic       luma_tv_presence_flag_o,
  input wire logic       composite_tv_presence_flag_o,
  input wire logic       tv_presence_flag_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  // Sync merge and subcarrier rate
  AST_COMBINED_SYNC: assert property (combined_sync_n_o == ($past(hsync_n_i, 3) ~^ $past(vsync_n_i, 3)))
    else $error("combined sync mismatch");
  AST_SUB_RATE: assert property ($changed(sub_sin_o) |=> $stable(sub_sin_o) ##1 $changed(sub_sin_o))
    else $error("subcarrier not at quarter rate");
  // Burst vectors per standard
  AST_NTSC_BURST: assert property (burst_gate_o && !pal_mode_i |-> burst_u_o == AX_NEG && burst_v_o == AX_ZERO)
    else $error("ntsc burst vector wrong");
  AST_PAL_BURST: assert property (burst_gate_o && pal_mode_i |-> burst_u_o == AX_NEG && burst_v_o[0])
    else $error("pal burst vector wrong");
  // Offset window length
  AST_OFFS: assert property ($rose(offset_cancel_o) |-> ##199 offset_cancel_o ##1 !offset_cancel_o)
    else $error("offset window length wrong");
  // Driver and flag relations
  AST_CHROMA: assert property (chroma_drive_pin_o == luma_drive_on_o && luma_tv_presence_flag_o == luma_drive_on_o
    && composite_tv_presence_flag_o == composite_drive_on_o)
    else $error("chroma or flag differs from driver");
  AST_PRES: assert property ($stable(luma_tv_presence_flag_o) && $stable(composite_tv_presence_flag_o)
    |-> tv_presence_flag_o == (luma_tv_presence_flag_o || composite_tv_presence_flag_o))
    else $error("presence pin not or of flags");
  AST_DRV_UPD: assert property ($changed(composite_drive_on_o) |-> $past(load_check_o) || $past(load_check_o, 2))
    else $error("driver changed outside check");
endmodule // vetc_timing_chk

bind vetc_timing vetc_timing_chk vetc_timing_chk_i (.core_clk_i, .reset_i, .hsync_n_i, .vsync_n_i, .pal_mode_i,
  .combined_sync_n_o, .sub_sin_o, .burst_gate_o, .burst_u_o, .burst_v_o, .offset_cancel_o, .load_check_o,
  .luma_drive_on_o, .chroma_drive_pin_o, .composite_drive_on_o, .luma_tv_presence_flag_o,
  .composite_tv_presence_flag_o, .tv_presence_flag_o);

// file: sim/vetc_gfx_model.sv
// Graphics controller model driving the sync pins
`timescale 1ns/1ps
module vetc_gfx_model (
  input  wire logic core_clk_i,
  output logic      hsync_n_o,
  output logic      vsync_n_o
);
  // Syncs idle high; no picture drive, RGB sits at black
  initial
  begin
    hsync_n_o = 1'b1;
    vsync_n_o = 1'b1;
  end
  // Sync low for w cycles, then high for g cycles
  task automatic pulse(input int w, input int g);
    @(posedge core_clk_i);
    hsync_n_o <= 1'b0;
    repeat (w) @(posedge core_clk_i);
    hsync_n_o <= 1'b1;
    repeat (g - 1) @(posedge core_clk_i);
  endtask
  // Short field: one line pulse, two half-line pulses, odd pulse count
  task automatic field();
    pulse(560, 5);
    pulse(20, 5);
    pulse(20, 5);
  endtask
  // Vertical pin level
  task automatic vlevel(input logic v);
    @(posedge core_clk_i);
    vsync_n_o <= v;
  endtask
endmodule // vetc_gfx_model

// file: sim/tb.sv
// Testbench for the timing control block
`timescale 1ns/1ps
module tb;
  import vetc_pkg::*;
  logic core_clk_i, reset_i, pal_mode_i, enable_i, luma_load_ok_i, composite_load_ok_i;
  wire  hsync_n, vsync_n;
  logic combined_sync_n, sin_q, cos_q, gate, offs, chk, l_on, c_on, cv_on, l_f, cv_f, tv;
  logic [1:0] bu, bv, pv;
  int   error_cnt, samples_checked, run_len, last_len;
  vetc_gfx_model vetc_gfx_model_i (.core_clk_i(core_clk_i), .hsync_n_o(hsync_n), .vsync_n_o(vsync_n));
  vetc_timing vetc_timing_i (.core_clk_i(core_clk_i), .reset_i(reset_i), .hsync_n_i(hsync_n), .vsync_n_i(vsync_n),
    .pal_mode_i(pal_mode_i), .enable_i(enable_i), .luma_load_ok_i(luma_load_ok_i),
    .composite_load_ok_i(composite_load_ok_i), .combined_sync_n_o(combined_sync_n), .sub_sin_o(sin_q), .sub_cos_o(cos_q),
    .burst_gate_o(gate), .burst_u_o(bu), .burst_v_o(bv), .offset_cancel_o(offs), .load_check_o(chk),
    .luma_drive_on_o(l_on), .chroma_drive_pin_o(c_on), .composite_drive_on_o(cv_on),
    .luma_tv_presence_flag_o(l_f), .composite_tv_presence_flag_o(cv_f), .tv_presence_flag_o(tv));
  // Clock
  initial
  begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  // Length of the last load check interval
  always @(negedge core_clk_i)
  begin
    if (chk === 1'b1) run_len++;
    else if (run_len != 0)
    begin
      last_len = run_len;
      run_len = 0;
    end
  end
  task automatic check(input string what, input logic [12:0] exp, input logic [12:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic do_reset(input logic pal);
    @(posedge core_clk_i);
    reset_i    <= 1'b1;
    pal_mode_i <= pal;
    repeat (3) @(posedge core_clk_i);
    reset_i <= 1'b0;
    pv = 2'h0;
  endtask
  // One line: sample burst, phase and offset window at fixed spots
  task automatic line_chk(input logic pal, input int w, input logic inv);
    logic c0;
    logic ok;
    ok = pal ? (w >= PAL_SYNC_MIN && w <= PAL_SYNC_MAX) : (w >= NTSC_SYNC_MIN && w <= NTSC_SYNC_MAX);
    fork
      vetc_gfx_model_i.pulse(w, 2000 - w);
      begin
        repeat (1100) @(negedge core_clk_i);
        check("burst_early", 0, gate);
        repeat (300) @(negedge core_clk_i);
        check("burst_gate", ok, gate);
        if (ok) check("burst_u", AX_NEG, bu);
        if (ok && !pal) check("burst_v", AX_ZERO, bv);
        if (ok && pal && pv !== 2'h0) check("burst_v", {~pv[1], 1'b1}, bv);
        if (ok) pv = bv;
        c0 = cos_q;
        @(negedge core_clk_i);
        check("cos_phase", inv, sin_q ^ c0);
        repeat (378) @(negedge core_clk_i);
        check("offset_on", 1, offs);
        repeat (121) @(negedge core_clk_i);
        check("offset_off", 0, offs);
        check("burst_end", 0, gate);
      end
    join
  endtask
  task automatic scen_lines(input logic pal);
    int wt [2][5] = '{'{559, 560, 1060, 700, 1061}, '{659, 660, 1080, 700, 1081}};
    do_reset(pal);
    for (int i = 0; i < 5; i++) line_chk(pal, wt[pal][i], pal && i % 2 == 0);
  endtask
  task automatic scen_combined_sync();
    vetc_gfx_model_i.vlevel(1'b0);
    repeat (5) @(negedge core_clk_i);
    check("combined_sync", 0, combined_sync_n);
    vetc_gfx_model_i.vlevel(1'b1);
  endtask
  // Two check rounds: luma gains a load, then loses it while composite gains one
  task automatic scen_load();
    int n;
    do_reset(1'b0);
    for (int p = 0; p < 2; p++)
    begin
      luma_load_ok_i      <= (p == 0);
      composite_load_ok_i <= (p == 1);
      n = 0;
      while (chk !== 1'b1 && n < 70)
      begin
        vetc_gfx_model_i.field();
        n++;
      end
      check("field_count", 64, n);
      for (int k = 0; k < 5000 && chk === 1'b1; k++) @(negedge core_clk_i);
      repeat (4) @(negedge core_clk_i);
      check("check_len", CHECK_END, last_len);
      check("drivers", {p == 0, p == 1}, {l_on, cv_on});
      check("flags", {p == 0, p == 1}, {l_f, cv_f});
      check("chroma", l_on, c_on);
      check("presence", 1, tv);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog
  initial
  begin
    #600000;
    error_cnt++;
    end_of_test();
  end
  // Main sequence
  initial
  begin
    reset_i = 1'b1;
    pal_mode_i = 1'b0;
    enable_i = 1'b1;
    luma_load_ok_i = 1'b0;
    composite_load_ok_i = 1'b0;
    error_cnt = 0;
    samples_checked = 0;
    run_len = 0;
    last_len = 0;
    scen_lines(1'b0);
    scen_lines(1'b1);
    scen_combined_sync();
    scen_load();
    end_of_test();
  end
endmodule // tb
